// [rtl/dac_ctrl_pkg.sv]
// Constants and carrier types for the host-side converter latch controller.
// Assumes one 25 MHz clock and an Avalon-MM master with waitrequest.
// Operation
// RL1: Code passes input then converter register.
// RL2: Converter holds output while input holds next.
// RL3: Shared transfer updates only written converters.
// RL4: Floating inputs read as one; drive all.
// RL5: Separate selects for input and transfer.
// RL6: Latch enable qualifies input chip select.
// RL7: Latch enable low freezes input register.
// RL8: Stand-alone double buffer: two strobes.
// RL9: Strobe high leaves output unchanged.
// RL10: Single buffer: one register transparent.
// RL11: Single buffer latches in input register.
// RL12: Stand-alone single buffer strobes first only.
// RL13: All grounded, enable high: flow-through.
// RL14: 256 output steps for 8 bits.
// RL15: Latch enable high or from address.
// RL16: Input transparent when select, strobe low.
// RL17: Converter loads when strobe, transfer low.
// RL18: Bit 0 least, bit 7 most significant.
// RL19: Latches have no clock, reset.
`default_nettype none
package dac_ctrl_pkg;
  localparam int unsigned CODE_W        = 8;
  localparam int unsigned NUM_DAC       = 4;
  localparam int unsigned CLK_HZ        = 25000000;
  localparam int unsigned STROBE_NS     = 900;
  localparam int unsigned HOLD_NS       = 50;
  localparam int unsigned STROBE_CYC    = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned HOLD_CYC      = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0]  OFF_CODE      = 4'h0;
  localparam logic [3:0]  OFF_CTRL      = 4'h4;
  localparam logic [3:0]  OFF_CMD       = 4'h8;
  localparam logic [3:0]  OFF_STATUS    = 4'hC;
  localparam logic [1:0]  MODE_DOUBLE   = 2'h0;
  localparam logic [1:0]  MODE_SINGLE   = 2'h1;
  localparam logic [1:0]  MODE_FLOW     = 2'h2;
  localparam int unsigned CMD_LOAD_BIT  = 0;
  localparam int unsigned CMD_TRANSFER_CONTROL_N_BIT  = 1;
  localparam int unsigned CMD_SEL_LSB   = 8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD   = 3'b011
  } phase_e;

  typedef struct packed {
    logic [CODE_W-1:0] code_inputs;
    logic              input_latch_enable;
    logic              input_write_strobe_n;
    logic              transfer_write_strobe_n;
    logic              transfer_control_n;
  } dac_pins_s;
endpackage
`default_nettype wire

// [rtl/dac_latch_host.sv]
// Host-side controller for several double-buffered 8-bit converters.
// Assumes converters share the code bus, strobes and transfer line; one chip select each.
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`default_nettype none
module dac_latch_host
  import dac_ctrl_pkg::*;
#(
  parameter int unsigned N_DAC = NUM_DAC
) (
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [3:0]       avs_address_in,
  input  wire logic             avs_read_in,
  input  wire logic             avs_write_in,
  input  wire logic [31:0]      avs_writedata_in,
  output logic      [31:0]      avs_readdata_out,
  output logic                  avs_waitrequest_out,
  output dac_pins_s             pins_out,
  output logic      [N_DAC-1:0] chip_select_n_out
);
  localparam logic [7:0] STROBE_LEN = 8'(STROBE_CYC);
  localparam logic [7:0] HOLD_LEN   = 8'(HOLD_CYC);

  phase_e            state;
  phase_e            next_state;
  logic [7:0]        count;
  logic [CODE_W-1:0] code;
  logic [1:0]        mode;
  logic              freeze;
  logic              do_load;
  logic              do_transfer_control_n;
  logic [N_DAC-1:0]  sel;
  logic [N_DAC-1:0]  pending;
  logic              busy;
  logic              read_ack;

  wire cmd_wr    = avs_write_in && (avs_address_in == OFF_CMD);
  wire code_wr   = avs_write_in && (avs_address_in == OFF_CODE);
  wire ctrl_wr   = avs_write_in && (avs_address_in == OFF_CTRL);
  wire accept    = cmd_wr && (state == ST_IDLE);
  wire wait_busy = cmd_wr && (state != ST_IDLE);
  wire count_end = (count == 8'h00);
  wire is_flow   = (mode == MODE_FLOW);
  wire is_single = (mode == MODE_SINGLE);
  wire strobing  = (state == ST_STROBE);
  wire active    = (state != ST_IDLE);

  // Reads take one wait state so the registered data stand when waitrequest drops
  assign avs_waitrequest_out = wait_busy || (avs_read_in && !read_ack);
  assign busy                = active;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:   next_state = accept ? ST_SETUP : ST_IDLE;
      ST_SETUP:  next_state = count_end ? ST_STROBE : ST_SETUP;
      ST_STROBE: next_state = count_end ? ST_HOLD : ST_STROBE;
      ST_HOLD:   next_state = count_end ? ST_IDLE : ST_HOLD;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      count <= 8'h00;
    end else begin
      state <= next_state;
      if (accept || (active && count_end && state != ST_HOLD)) begin
        count <= (accept || state == ST_STROBE) ? HOLD_LEN : STROBE_LEN;
      end else if (!count_end) begin
        count <= count - 8'h01;
      end
    end
  end

  // RL14 full code width
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code   <= 8'h00;
      mode   <= MODE_DOUBLE;
      freeze <= 1'b0;
    end else begin
      if (code_wr && !active) begin
        code <= avs_writedata_in[CODE_W-1:0];
      end
      if (ctrl_wr) begin
        mode   <= avs_writedata_in[1:0];
        freeze <= avs_writedata_in[4];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      do_load <= 1'b0;
      do_transfer_control_n <= 1'b0;
      sel     <= '0;
      pending <= '0;
    end else begin
      if (accept) begin
        do_load <= avs_writedata_in[CMD_LOAD_BIT];
        do_transfer_control_n <= avs_writedata_in[CMD_TRANSFER_CONTROL_N_BIT];
        sel     <= avs_writedata_in[CMD_SEL_LSB +: N_DAC];
      end
      // RL3 track written inputs
      if (state == ST_HOLD && count_end) begin
        pending <= do_transfer_control_n ? '0 : (do_load && !freeze ? (pending | sel) : pending);
      end
    end
  end

  // RL5 per-converter input select
  assign chip_select_n_out = (is_flow || (active && do_load)) ? ~(is_flow ? {N_DAC{1'b1}} : sel) : {N_DAC{1'b1}};

  // RL18 bit order kept
  assign pins_out.code_inputs = code;
  // RL15 enable driven, RL7 freeze
  assign pins_out.input_latch_enable = !freeze;
  // RL8 first strobe loads input, RL12 single strobe, RL13 flow held low
  assign pins_out.input_write_strobe_n = is_flow ? 1'b0 : !(strobing && do_load);
  // RL10 transfer path transparent, RL11 input latches, RL9 idle high
  assign pins_out.transfer_write_strobe_n = (is_flow || is_single) ? 1'b0 : !(strobing && do_transfer_control_n);
  // RL4 every pin driven, RL17 transfer with strobe
  assign pins_out.transfer_control_n = (is_flow || is_single) ? 1'b0 : !(active && do_transfer_control_n);

  wire [31:0] rd_status = {{(28 - N_DAC){1'b0}}, pending, 3'h0, busy};
  wire [31:0] rd_mux    = (avs_address_in == OFF_CODE)   ? {24'h0, code} :
                          (avs_address_in == OFF_CTRL)   ? {27'h0, freeze, 2'h0, mode} :
                          (avs_address_in == OFF_STATUS) ? rd_status : 32'h0;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0;
      read_ack         <= 1'b0;
    end else begin
      read_ack <= avs_read_in && !read_ack;
      if (avs_read_in && !read_ack) begin
        avs_readdata_out <= rd_mux;
      end
    end
  end
endmodule
`default_nettype wire

// [bench/dac_conv_model.sv]
// Behavioural model of several converters' two code latches.
// Shares code, strobes and transfer lines; one select each.
`default_nettype none
module dac_conv_model import dac_ctrl_pkg::*; #(parameter int unsigned N = NUM_DAC) (
  input  wire dac_pins_s                pins_in,
  input  wire logic [N-1:0]             cs_n_in,
  output logic      [N-1:0][CODE_W-1:0] level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [N-1:0][CODE_W-1:0] in_q;
  // every pin driven, bit 0 LSB
  always @* for (int i = 0; i < N; i++)
    if (!cs_n_in[i] && !pins_in.input_write_strobe_n && pins_in.input_latch_enable) in_q[i] = pins_in.code_inputs;
  always @* for (int i = 0; i < N; i++)
    if (!pins_in.transfer_write_strobe_n && !pins_in.transfer_control_n) level_out[i] = in_q[i];
endmodule
`default_nettype wire

// [bench/dac_latch_host_props.sv]
// Port assertions for the host latch controller.
// Bound into dac_latch_host; one clock, async low reset.
`default_nettype none
module dac_latch_host_props import dac_ctrl_pkg::*; #(parameter int unsigned N_DAC = NUM_DAC) (
  input wire logic             sys_clk_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out,
  input wire logic [3:0]       avs_address_in,
  input wire logic [31:0]      avs_writedata_in, avs_readdata_out,
  input wire dac_pins_s        pins_out,
  input wire logic [N_DAC-1:0] chip_select_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Mode writes move the pins at once, so such edges are no pulse edges
  wire ctl_wr = avs_write_in && avs_address_in == OFF_CTRL;
  wire sel = chip_select_n_out != '1;
  wire s1 = pins_out.input_write_strobe_n;
  sequence pulse_end; ##23 !s1 ##1 s1; endsequence
  chk_sel_strobe:
    assert property (!s1 |-> sel) else $error("strobe without select");
  chk_strobe_width:
    assert property ($fell(s1) && !$past(ctl_wr) |-> pulse_end) else $error("strobe width");
  chk_data_hold:
    assert property ($rose(s1) && !$past(ctl_wr) |-> $stable(pins_out.code_inputs) [*3]) else $error("data hold");
  chk_transfer_control_n_pair:
    assert property (!pins_out.transfer_write_strobe_n |-> !pins_out.transfer_control_n) else $error("transfer_control_n");
  chk_freeze_level:
    assert property (ctl_wr |=> pins_out.input_latch_enable == !$past(avs_writedata_in[4])) else $error("freeze");
  chk_wait_cmd:
    assert property (avs_waitrequest_out |-> avs_read_in || (avs_write_in && avs_address_in == OFF_CMD))
      else $error("wait");
  chk_read_one_wait:
    assert property (avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("read wait");
  chk_reset_idle:
    assert property ($rose(rst_n_in) |-> !sel && s1 && pins_out.transfer_write_strobe_n) else $error("reset");
endmodule
bind dac_latch_host dac_latch_host_props #(.N_DAC(N_DAC)) i_props (.sys_clk_in, .rst_n_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .avs_address_in, .avs_writedata_in, .avs_readdata_out, .pins_out,
  .chip_select_n_out);
`default_nettype wire

// [bench/dac_latch_host_test.sv]
// Bench for the host latch controller with a converter model.
// Avalon-MM master tasks on a 25 MHz clock.
`default_nettype none
module dac_latch_host_test import dac_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'h0, rst_n_in = 1'h0, rd = 1'h0, wr = 1'h0, wreq;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata, q;
  dac_pins_s pins;
  logic [NUM_DAC-1:0] cs_n;
  logic [NUM_DAC-1:0][7:0] lvl;
  int errors = 0, check_count = 0;
  initial forever #20 sys_clk_in = ~sys_clk_in;
  dac_latch_host i_dut (.sys_clk_in, .rst_n_in, .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .pins_out(pins),
    .chip_select_n_out(cs_n));
  dac_conv_model i_model (.pins_in(pins), .cs_n_in(cs_n), .level_out(lvl));
  task automatic report_and_stop;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Waitrequest is read mid-cycle, where the combinational answer has settled
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    logic busy;
    n = 0;
    @(posedge sys_clk_in);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(negedge sys_clk_in);
      busy = wreq;
      q = rdata;
      @(posedge sys_clk_in);
      n++;
    end while (busy !== 1'h0 && n < 100);
    wr <= 1'h0;
    rd <= 1'h0;
    if (busy !== 1'h0) begin
      errors++;
      report_and_stop();
    end
    @(negedge sys_clk_in);
  endtask
  task automatic idle;
    repeat (60) begin
      acc(1'h0, OFF_STATUS, 32'h0);
      if (q[0] === 1'h0) return;
    end
    errors++;
    report_and_stop();
  endtask
  task automatic load(input logic [31:0] c, input logic [31:0] k);
    acc(1'h1, OFF_CODE, c);
    acc(1'h1, OFF_CMD, k);
    idle();
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    @(negedge sys_clk_in);
    cmp("reset pins", 32'h00FF, {pins, cs_n});
    load(32'h00, 32'hF03);
    load(32'hA5, 32'h301);
    cmp("pending", 32'h30, q & 32'hF0);
    cmp("held", 32'h0, lvl[0]);
    acc(1'h1, OFF_CODE, 32'h3C);
    acc(1'h1, OFF_CMD, 32'h401);
    acc(1'h1, OFF_CMD, 32'hF02);
    idle();
    cmp("shared", 32'h003CA5A5, lvl);
    cmp("cleared", 32'h0, q & 32'hF0);
    acc(1'h1, OFF_CTRL, 32'h10);
    load(32'h77, 32'h103);
    cmp("frozen", 32'hA5, lvl[0]);
    acc(1'h1, OFF_CTRL, {30'h0, MODE_SINGLE});
    load(32'h5A, 32'h101);
    cmp("single", 32'h5A, lvl[0]);
    acc(1'h1, OFF_CTRL, {30'h0, MODE_FLOW});
    acc(1'h1, OFF_CODE, 32'hC3);
    cmp("flow", 32'hC3, lvl[0]);
    acc(1'h0, OFF_CODE, 32'h0);
    cmp("code readback", 32'hC3, q);
    report_and_stop();
  end
endmodule
`default_nettype wire
